// ### common/dds_pkg.sv
// constants shared by the phase accumulator synthesizer files
package dds_pkg;
  // datapath widths
  localparam int ACC_W = 24;          // phase accumulator width
  localparam int SET_W = 22;          // frequency setting width
  localparam int DEV_W = 8;           // fsk deviation width
  localparam int DEV_SHIFT = 2;       // deviation weight is four
  localparam int LUT_AW = 8;          // sine table address width
  localparam int QTR_AW = 6;          // quarter-wave table address width
  localparam int MAG_W = 10;          // quarter-wave magnitude width
  localparam int DAC_W = 11;          // dac sample width
  localparam int ADR_W = 8;           // wishbone byte address width
  localparam int GAIN_W = 3;          // acquisition gain field width
  localparam int PIN_N = 4;           // synchronised input pins

  // register byte offsets
  localparam logic [ADR_W-1:0] REG_FREQ0 = 8'h00; // mode0 setting
  localparam logic [ADR_W-1:0] REG_FREQ1 = 8'h04; // mode1 setting
  localparam logic [ADR_W-1:0] REG_CTRL = 8'h08;  // control word
  localparam logic [ADR_W-1:0] REG_STAT = 8'h0C;  // pin and loop status
  localparam logic [ADR_W-1:0] REG_PHASE = 8'h10; // live accumulator
  localparam logic [ADR_W-1:0] REG_WORD = 8'h14;  // effective freq word

  // control word field positions
  localparam int CTRL_DEV_LSB = 0;    // fsk_deviation_value [7:0]
  localparam int CTRL_MOD_SEL = 16;   // modulation_select_bit, 0 = fsk
  localparam int CTRL_PRESC = 17;     // 0 = divide by 256, 1 = by 512
  localparam int CTRL_GAIN_LSB = 18;  // acquisition_gain_field [20:18]
  localparam int CTRL_VCO_EN = 21;    // vco_enable_bit

  // status word bit positions
  localparam int STAT_MODE = 0;       // synchronised mode pin
  localparam int STAT_TXD = 1;        // synchronised transmit data pin
  localparam int STAT_LOCK = 2;       // synchronised loop lock pin
  localparam int STAT_FSK = 3;        // deviation currently added

  // writable bits and reset values
  localparam logic [31:0] FREQ_MASK = 32'h003FFFFF;
  localparam logic [31:0] CTRL_MASK = 32'h003F00FF;
  localparam logic [SET_W-1:0] FREQ_RST = 22'h000000;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
endpackage

// ### src/dds_phase_acc.sv
// phase accumulator synthesizer with two settings and fsk offset
// Contract
// - a 24-bit phase accumulator advances on every reference clock cycle outside standby
// - each clock outside standby adds the frequency word and wraps at full range
// - accumulator output addresses a sine table feeding the dac
// - each frequency setting is 22 bits with two zero top bits
// - two independent settings are kept, one per mode
// - the mode pin selects which setting drives the frequency word
// - deviation applies only while the modulation select bit is zero
// - the 8-bit deviation enters shifted left two places
// - transmit data high adds four times deviation to the setting
// - setting registers keep their values through standby
// - a control bit selects feedback prescaler 256 or 512
// - a three-bit gain field scales acquisition pulses while unlocked
// - the acquisition pump runs only while the loop is unlocked
`timescale 1ns/1ns
module dds_phase_acc
  import dds_pkg::*;
(
  input wire logic clk_i,             // 250 mhz reference clock
  input wire logic rst_i,             // synchronous reset, active high
  input wire logic wb_cyc_i,          // wishbone cycle
  input wire logic wb_stb_i,          // wishbone strobe
  input wire logic wb_we_i,           // wishbone write enable
  input wire logic [ADR_W-1:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i,    // wishbone byte lanes
  input wire logic [31:0] wb_dat_i,   // wishbone write data
  output logic [31:0] wb_dat_o,       // wishbone read data
  output logic wb_ack_o,              // wishbone acknowledge
  input wire logic mode_i,            // mode pin, 1 selects mode1
  input wire logic tx_data_i,         // transmit data pin
  input wire logic pll_lock_i,        // loop lock indication
  input wire logic standby_i,         // standby, accumulator halts
  output logic [DAC_W-1:0] dac_data_o, // sample to the dac
  output logic prescaler_512_o,       // 1 = divide by 512
  output logic [GAIN_W-1:0] acq_gain_o, // acquisition gain, 0 when locked
  output logic acq_pump_en_o,         // acquisition pump enable
  output logic vco_enable_o           // internal vco enable
);
  // register state
  logic [SET_W-1:0] freq0_r;
  logic [SET_W-1:0] freq1_r;
  logic [31:0] ctrl_r;
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic ack_r;
  logic [31:0] rdat_r;
  logic [GAIN_W-1:0] gain_r;
  logic pump_r;

  // synchronised pins
  logic [PIN_N-1:0] pin_raw_w;
  logic [PIN_N-1:0] pin_s_w;
  logic mode_s;
  logic txd_s;
  logic lock_s;
  logic stby_s;

  // bus decode
  logic req_w;
  logic wr_en_w;
  logic hit_f0_w;
  logic hit_f1_w;
  logic hit_ctrl_w;
  logic hit_stat_w;
  logic hit_phase_w;
  logic hit_word_w;
  logic [31:0] rd_mux_w;
  logic [31:0] f0_wr_w;
  logic [31:0] f1_wr_w;
  logic [31:0] ctrl_wr_w;

  // datapath
  logic [ACC_W-1:0] freq_sel_w;
  logic [ACC_W-1:0] dev_word_w;
  logic fsk_on_w;
  logic [ACC_W-1:0] word_w;
  logic [ACC_W-1:0] acc_sum_w;
  logic [31:0] status_w;

  // byte-lane merge of write data into an old register value
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] din,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = din[8*b +: 8];
      end
    end
    return r;
  endfunction

  // all external levels pass the three-stage synchroniser
  assign pin_raw_w = {standby_i, pll_lock_i, tx_data_i, mode_i};
  dds_pin_sync #(
    .W(PIN_N)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_raw_w),
    .pin_o(pin_s_w)
  );
  assign mode_s = pin_s_w[0];
  assign txd_s = pin_s_w[1];
  assign lock_s = pin_s_w[2];
  assign stby_s = pin_s_w[3];

  // wishbone decode: every access is acknowledged, unmapped reads zero
  assign req_w = wb_cyc_i & wb_stb_i;
  assign wr_en_w = req_w & wb_we_i & ack_r;
  assign hit_f0_w = wb_adr_i == REG_FREQ0;
  assign hit_f1_w = wb_adr_i == REG_FREQ1;
  assign hit_ctrl_w = wb_adr_i == REG_CTRL;
  assign hit_stat_w = wb_adr_i == REG_STAT;
  assign hit_phase_w = wb_adr_i == REG_PHASE;
  assign hit_word_w = wb_adr_i == REG_WORD;

  // merged write values, bits outside each field stay zero
  assign f0_wr_w = wmerge({10'h000, freq0_r}, wb_dat_i, wb_sel_i)
                   & FREQ_MASK;
  assign f1_wr_w = wmerge({10'h000, freq1_r}, wb_dat_i, wb_sel_i)
                   & FREQ_MASK;
  assign ctrl_wr_w = wmerge(ctrl_r, wb_dat_i, wb_sel_i) & CTRL_MASK;

  // status word shows the block's own view of its pins
  assign status_w = {28'h0000000, fsk_on_w, lock_s, txd_s, mode_s};

  // read selection
  assign rd_mux_w = hit_f0_w ? {10'h000, freq0_r} :
                    hit_f1_w ? {10'h000, freq1_r} :
                    hit_ctrl_w ? ctrl_r :
                    hit_stat_w ? status_w :
                    hit_phase_w ? {8'h00, acc_r} :
                    hit_word_w ? {8'h00, word_w} : 32'h00000000;

  // one wait state: ack one cycle after the request, then dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r <= req_w & ~ack_r;
      if (req_w & ~ack_r) begin
        rdat_r <= rd_mux_w;
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // static setting registers, only a write or reset alters them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq0_r <= FREQ_RST;
      freq1_r <= FREQ_RST;
      ctrl_r <= CTRL_RST;
    end else if (wr_en_w) begin
      if (hit_f0_w) begin
        freq0_r <= f0_wr_w[SET_W-1:0];
      end
      if (hit_f1_w) begin
        freq1_r <= f1_wr_w[SET_W-1:0];
      end
      if (hit_ctrl_w) begin
        ctrl_r <= ctrl_wr_w;
      end
    end
  end

  // mode pin picks the setting, top two bits forced to zero
  assign freq_sel_w = mode_s ? {2'b00, freq1_r}
                             : {2'b00, freq0_r};
  // deviation weighted by four in the frequency word
  assign dev_word_w = {{(ACC_W-DEV_W-DEV_SHIFT){1'b0}},
                       ctrl_r[CTRL_DEV_LSB +: DEV_W], 2'b00};
  // offset only in fsk mode with transmit data high
  assign fsk_on_w = ~ctrl_r[CTRL_MOD_SEL] & txd_s;
  assign word_w = fsk_on_w ? freq_sel_w + dev_word_w
                           : freq_sel_w;
  // modulo 2^24 sum wraps naturally
  assign acc_sum_w = acc_r + word_w;
  assign acc_nxt = stby_s ? acc_r : acc_sum_w;

  // phase accumulator, one step per reference cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // top accumulator bits address the sine table
  dds_sine_rom u_rom (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .phase_i(acc_r[ACC_W-1 -: LUT_AW]),
    .sample_o(dac_data_o)
  );

  // analogue loop controls, pump and gain only while unlocked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_r <= '0;
      pump_r <= 1'b0;
    end else begin
      pump_r <= ~lock_s;
      gain_r <= lock_s ? '0 : ctrl_r[CTRL_GAIN_LSB +: GAIN_W];
    end
  end
  assign acq_gain_o = gain_r;
  assign acq_pump_en_o = pump_r;
  assign prescaler_512_o = ctrl_r[CTRL_PRESC];
  assign vco_enable_o = ctrl_r[CTRL_VCO_EN];

  // checks on the datapath and loop controls
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_acc_step: assert property (!stby_s |=> acc_r == $past(acc_sum_w))
    else $error("accumulator did not advance by the word");
  a_acc_wrap: assert property (
    !stby_s && acc_r[ACC_W-1] && !acc_sum_w[ACC_W-1] |=> acc_r < $past(acc_r))
    else $error("accumulator did not wrap at full range");
  a_word_msbs: assert property (freq_sel_w[ACC_W-1 -: 2] == 2'b00)
    else $error("frequency setting top bits not zero");
  a_mode_one: assert property (
    mode_s && ctrl_r[CTRL_MOD_SEL] |-> word_w == {2'b00, freq1_r})
    else $error("mode1 setting not selected");
  a_mode_zero: assert property (
    !mode_s && !txd_s |-> word_w == {2'b00, freq0_r})
    else $error("mode0 setting not selected");
  a_no_dev_fm: assert property (ctrl_r[CTRL_MOD_SEL] |-> word_w == freq_sel_w)
    else $error("deviation added outside fsk mode");
  a_fsk_offset: assert property (
    !ctrl_r[CTRL_MOD_SEL] && txd_s
    |-> word_w - freq_sel_w == ACC_W'(4 * ctrl_r[CTRL_DEV_LSB +: DEV_W]))
    else $error("fsk offset is not four times deviation");
  a_dev_lsbs: assert property (dev_word_w[1:0] == 2'b00)
    else $error("deviation low bits not zero");
  a_hold_stby: assert property (
    stby_s && !wr_en_w |=> $stable(freq0_r) && $stable(freq1_r)
    && $stable(ctrl_r) && $stable(acc_r))
    else $error("settings changed during standby");
  a_presc_write: assert property (
    wr_en_w && hit_ctrl_w && wb_sel_i[2]
    |=> prescaler_512_o == $past(wb_dat_i[CTRL_PRESC]))
    else $error("prescaler select not taken from write");
  a_pump_off: assert property (lock_s [*2] |=> !acq_pump_en_o
    && acq_gain_o == 3'h0)
    else $error("acquisition pump on while locked");
  a_gain_unlk: assert property (
    !lock_s && $stable(ctrl_r)
    |=> acq_gain_o == $past(ctrl_r[CTRL_GAIN_LSB +: GAIN_W]))
    else $error("acquisition gain not applied while unlocked");
  a_wb_ack: assert property (req_w && !ack_r |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");

  c_fsk_mark: cover property (!ctrl_r[CTRL_MOD_SEL] && $rose(txd_s));
  c_mode_swap: cover property ($rose(mode_s) ##[1:20] $fell(mode_s));
  c_acc_wrap: cover property (acc_r[ACC_W-1] ##1 !acc_r[ACC_W-1]);
  c_lock_gain: cover property ($rose(lock_s) ##2 !acq_pump_en_o);
endmodule

// ### src/dds_pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
module dds_pin_sync
  import dds_pkg::*;
#(
  parameter int W = 1                 // number of pins
) (
  input wire logic clk_i,             // system clock
  input wire logic rst_i,             // synchronous reset, active high
  input wire logic [W-1:0] pin_i,     // asynchronous pin levels
  output logic [W-1:0] pin_o          // filtered synchronous levels
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] agree_w;

  // stages two and three agreeing marks a settled change
  assign agree_w = ~(s2_r ^ s3_r);
  assign pin_o = q_r;

  // the first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= (s3_r & agree_w) | (q_r & ~agree_w);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_sync_agree: assert property (agree_w == '1 |=> pin_o == $past(s3_r))
    else $error("filtered pin did not take the agreed level");
endmodule

// ### src/dds_sine_rom.sv
// quarter-wave sine lookup feeding the dac sample register
`timescale 1ns/1ns
module dds_sine_rom
  import dds_pkg::*;
(
  input wire logic clk_i,             // system clock
  input wire logic rst_i,             // synchronous reset, active high
  input wire logic [LUT_AW-1:0] phase_i, // top accumulator bits
  output logic [DAC_W-1:0] sample_o   // offset-binary dac code
);
  // magnitudes of one quarter period, sampled at half-step centres
  localparam logic [MAG_W-1:0] QTAB [64] = '{
    10'h00D, 10'h026, 10'h03F, 10'h058, 10'h071, 10'h08A, 10'h0A3, 10'h0BB,
    10'h0D4, 10'h0EC, 10'h105, 10'h11D, 10'h135, 10'h14D, 10'h164, 10'h17C,
    10'h193, 10'h1AA, 10'h1C1, 10'h1D7, 10'h1ED, 10'h203, 10'h219, 10'h22E,
    10'h243, 10'h257, 10'h26B, 10'h27F, 10'h293, 10'h2A6, 10'h2B8, 10'h2CA,
    10'h2DC, 10'h2EE, 10'h2FE, 10'h30F, 10'h31F, 10'h32E, 10'h33D, 10'h34C,
    10'h35A, 10'h367, 10'h374, 10'h380, 10'h38C, 10'h397, 10'h3A2, 10'h3AC,
    10'h3B6, 10'h3BF, 10'h3C7, 10'h3CF, 10'h3D7, 10'h3DD, 10'h3E3, 10'h3E9,
    10'h3EE, 10'h3F2, 10'h3F6, 10'h3F9, 10'h3FB, 10'h3FD, 10'h3FE, 10'h3FF};
  localparam logic [DAC_W-1:0] MID = 11'h400; // zero level of the dac
  localparam logic [DAC_W-1:0] LOW = 11'h3FF; // base of negative half

  logic [QTR_AW-1:0] idx_w;
  logic [DAC_W-1:0] mag_w;
  logic [DAC_W-1:0] code_w;
  logic [DAC_W-1:0] sample_r;

  // second and fourth quarters read the table backwards
  assign idx_w = phase_i[LUT_AW-2] ? ~phase_i[QTR_AW-1:0]
                                   : phase_i[QTR_AW-1:0];
  assign mag_w = {1'b0, QTAB[idx_w]};
  // negative half mirrors below mid-scale
  assign code_w = phase_i[LUT_AW-1] ? LOW - mag_w : MID + mag_w;
  assign sample_o = sample_r;

  // registered table output drives the dac
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_r <= MID;
    end else begin
      sample_r <= code_w;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rom_start: assert property (phase_i == 8'h00 |=> sample_o == 11'h40D)
    else $error("table entry for phase zero is wrong");
  a_rom_odd: assert property (phase_i == 8'h80 |=> sample_o == 11'h3F2)
    else $error("table entry for half period is wrong");
endmodule

// ### test/dds_pll_model.sv
// behavioural dac and analogue loop model that reports lock
`timescale 1ns/1ns
module dds_pll_model
  import dds_pkg::*;
#(
  parameter int LOCK_CYC = 20         // cycles of activity before lock
) (
  input wire logic clk_i,             // reference clock
  input wire logic rst_i,             // synchronous reset, active high
  input wire logic [DAC_W-1:0] dac_data_i, // sample from the block
  input wire logic prescaler_512_i,   // 1 = feedback divide by 512
  input wire logic lock_allow_i,      // bench lets the loop settle
  output logic pll_lock_o             // loop lock indication
);
  int cnt;
  logic [DAC_W-1:0] last_r;
  // the longer feedback ratio settles more slowly
  always_ff @(posedge clk_i) begin
    last_r <= dac_data_i;
    if (rst_i || !lock_allow_i) begin
      cnt <= 0;
      pll_lock_o <= 1'b0;
    end else if (cnt < (prescaler_512_i ? 2 * LOCK_CYC : LOCK_CYC)) begin
      if (dac_data_i != last_r) cnt <= cnt + 1; // needs a moving sine
    end else begin
      pll_lock_o <= 1'b1;
    end
  end
endmodule

// ### test/testbench.sv
// self-checking bench for the phase accumulator synthesizer
`timescale 1ns/1ns
module testbench
  import dds_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] dat_w = '0, wb_dat_o, q, q2, f0, f1, ctl, d;
  logic wb_ack_o, mode = 1'b0, txd = 1'b0, stby = 1'b0, allow = 1'b0;
  logic pll_lock, prescaler_512_o, acq_pump_en_o, vco_enable_o;
  logic [DAC_W-1:0] dac_data_o;
  logic [GAIN_W-1:0] acq_gain_o;
  int num_errors = 0, check_count = 0, cyc_cnt = 0, t1, t2;
  // reference clock
  always #2 clk = ~clk;
  always @(posedge clk) cyc_cnt <= cyc_cnt + 1;
  dds_phase_acc i_dds_phase_acc (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mode_i(mode), .tx_data_i(txd), .pll_lock_i(pll_lock),
    .standby_i(stby), .dac_data_o(dac_data_o),
    .prescaler_512_o(prescaler_512_o), .acq_gain_o(acq_gain_o),
    .acq_pump_en_o(acq_pump_en_o), .vco_enable_o(vco_enable_o));
  dds_pll_model i_dds_pll_model (.clk_i(clk), .rst_i(rst),
    .dac_data_i(dac_data_o), .prescaler_512_i(prescaler_512_o),
    .lock_allow_i(allow), .pll_lock_o(pll_lock));
  // verdict and end of run
  task summarize();
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled high
  task wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] dw,
          input logic [3:0] s, output logic [31:0] r, output int t);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= dw; sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      summarize();
    end
    r = wb_dat_o;
    t = cyc_cnt;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [ADR_W-1:0] a, input logic [31:0] dw);
    logic [31:0] r;
    int t;
    wb(1'b1, a, dw, 4'hF, r, t);
  endtask
  task rd(input logic [ADR_W-1:0] a, output logic [31:0] r);
    int t;
    wb(1'b0, a, 32'h0, 4'hF, r, t);
  endtask
  // bounded wait for the pump enable to reach a level
  task wait_pump(input logic lvl);
    int n;
    n = 0;
    while (acq_pump_en_o !== lvl && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      num_errors++;
      summarize();
    end
    repeat (2) @(posedge clk);
  endtask
  function automatic logic [31:0] exp_word(input logic [31:0] f,
      input logic [31:0] c, input logic tx);
    return (f & FREQ_MASK) + ((!c[CTRL_MOD_SEL] && tx) ?
      {22'h0, c[7:0], 2'b00} : 32'h0);
  endfunction
  function automatic logic [31:0] sine_code(input logic [7:0] p);
    logic [5:0] ix;
    int m;
    ix = p[6] ? ~p[5:0] : p[5:0];
    m = $rtoi(1023.0 * $sin((ix + 0.5) * 3.14159265358979 / 128.0) + 0.5);
    return p[7] ? 32'h3FF - m : 32'h400 + m;
  endfunction
  initial begin
    void'($urandom(32'h7db5cfb3));
    repeat (5) @(posedge clk);
    #1 check(dac_data_o, 32'h400); check(vco_enable_o, 0);
    @(posedge clk) rst <= 1'b0;
    rd(REG_CTRL, q); check(q, CTRL_RST);
    rd(8'h18, q); check(q, 32'h0);
    // random settings, modes and deviation through the word read-back
    for (int k = 0; k < 6; k++) begin
      f0 = $urandom(); f1 = $urandom(); ctl = $urandom();
      if (k < 2) ctl[CTRL_MOD_SEL] = 1'b0;
      mode <= k[0]; txd <= (k < 4) ? 1'b1 : $urandom_range(1);
      wr(REG_FREQ0, f0); wr(REG_FREQ1, f1); wr(REG_CTRL, ctl);
      rd(REG_FREQ0, q); check(q, f0 & FREQ_MASK);
      rd(REG_FREQ1, q); check(q, f1 & FREQ_MASK);
      rd(REG_CTRL, q); check(q, ctl & CTRL_MASK);
      check(prescaler_512_o, ctl[CTRL_PRESC]);
      check(vco_enable_o, ctl[CTRL_VCO_EN]);
      repeat (8) @(posedge clk);
      rd(REG_WORD, q); check(q, exp_word(k[0] ? f1 : f0, ctl, txd));
      // step between two reads of the live phase, with wrap
      wb(1'b0, REG_PHASE, 0, 4'hF, q, t1); wb(1'b0, REG_PHASE, 0, 4'hF, q2, t2);
      d = exp_word(k[0] ? f1 : f0, ctl, txd) * (t2 - t1);
      check(q2, (q + d) & 32'h00FFFFFF);
    end
    // partial lane write touches only the selected byte
    d = $urandom();
    wb(1'b1, REG_CTRL, d, 4'b0100, q, t1);
    rd(REG_CTRL, q);
    check(q, ((ctl & 32'hFF00FFFF) | (d & 32'h00FF0000)) & CTRL_MASK);
    ctl = q;
    // standby freezes the phase, settings survive, dac follows the table
    stby <= 1'b1; txd <= 1'b0; repeat (8) @(posedge clk);
    rd(REG_PHASE, q); rd(REG_PHASE, q2); check(q2, q); rd(REG_FREQ1, q2);
    check(q2, f1 & FREQ_MASK);
    rd(REG_STAT, q2); check(q2, 32'h00000001);
    check(dac_data_o, sine_code(q[23:16]));
    stby <= 1'b0;
    // acquisition pump and gain follow the loop lock
    wr(REG_CTRL, 32'h001C0000); wait_pump(1'b1);
    check(acq_gain_o, 3'h7);
    allow <= 1'b1; wait_pump(1'b0); check(acq_gain_o, 3'h0);
    allow <= 1'b0; wait_pump(1'b1); check(acq_gain_o, 3'h7);
    summarize();
  end
endmodule
